// >>> core/ids_pkg.sv
/*
  Shared constants and carriers for the injector driver supervisor.
  Assumes a single 100 MHz clock and the register port of the top module.
*/
package ids_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PEAK   = 8'h04;
  localparam logic [7:0] ADDR_HOST   = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0C;
  localparam logic [7:0] ADDR_VSET   = 8'h10;
  localparam logic [7:0] ADDR_CURR   = 8'h14;
  localparam logic [7:0] ADDR_TIME   = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIELD_MAX     = 255;
  localparam int PEAK_MAX_NS   = 500000;
  localparam int HV_MAX_NS     = 400000;
  localparam int RET_MAX_NS    = 1600000;
  localparam int WD_PERIOD_NS  = 100000000;
  // Cycles per interval step less one, rounded down so a full field never overruns.
  localparam logic [9:0] PEAK_STEP_CYC = 10'(PEAK_MAX_NS / CLK_PERIOD_NS / FIELD_MAX - 1);
  localparam logic [9:0] HV_STEP_CYC   = 10'(HV_MAX_NS / CLK_PERIOD_NS / FIELD_MAX - 1);
  localparam logic [9:0] RET_STEP_CYC  = 10'(RET_MAX_NS / CLK_PERIOD_NS / FIELD_MAX - 1);
  localparam int WD_TIMEOUT_CYC = WD_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] CAL_LAST_WORD = 2'h2;
  localparam int CRIT_FAULTS = 7;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic single_shot_trigger;
    logic single_shot_enable;
    logic safety_toggle_input;
    logic fault_clear_request;
    logic calibrate_request;
    logic boost_supply_enable;
    logic injection_permit;
    logic drive_unit_enable;
  } ids_ctrl_type;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_PULSE  = 2'b01,
    PH_RETURN = 2'b10
  } ids_phase_type;

  typedef struct packed {
    logic       drive_enable;
    logic       boost_run;
    logic [7:0] voltage_setpoint;
    logic [7:0] current_target;
    logic       high_voltage_drive;
    logic       energy_return;
  } ids_stage_type;
endpackage : ids_pkg

// >>> core/ids_supervisor.sv
/*
  Supervisor, calibration sender and pulse-phase controller of the injector driver.
  Assumes unit pins, fault pins and the fuel command come from outside the clock domain,
  and that software toggles the safety bit and drives the control bits over the register port.
*/
// Our own choices: the strobed register port and the placing of the registers.
module ids_supervisor #(
  parameter int WD_TIMEOUT = ids_pkg::WD_TIMEOUT_CYC
) (
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  input  wire logic                            unit_inserted,
  input  wire logic                            unit_powered,
  input  wire logic                            fuel_command,
  input  wire logic [ids_pkg::CRIT_FAULTS-1:0] critical_fault_in,
  output logic                                 unit_link_active,
  output logic                                 cal_word_valid,
  output logic      [15:0]                     cal_word_data,
  output logic      [7:0]                      link_control_word,
  output logic      [7:0]                      host_mode_word,
  output logic      [31:0]                     host_command_word,
  output ids_pkg::ids_stage_type               stage_cmd
);
  import ids_pkg::*;
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [CRIT_FAULTS+2:0] sync1_r;
  logic [CRIT_FAULTS+2:0] sync2_r;
  // Two flops on every unit, fuel and fault pin before any logic looks at it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {critical_fault_in, fuel_command, unit_powered, unit_inserted};
      sync2_r <= sync1_r;
    end
  end
  logic                   ins_s;
  logic                   pwr_s;
  logic                   fuel_s;
  logic [CRIT_FAULTS-1:0] flt_s;
  assign ins_s  = sync2_r[0];
  assign pwr_s  = sync2_r[1];
  assign fuel_s = sync2_r[2];
  assign flt_s  = sync2_r[CRIT_FAULTS+2:3];
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  ids_ctrl_type ctrl_r, ctrl_nxt;
  logic [7:0]   peak_r, peak_nxt;
  logic [15:0]  host_r, host_nxt;
  logic [31:0]  cmd_r, cmd_nxt;
  logic [15:0]  vset_r, vset_nxt, curr_r, curr_nxt, time_r, time_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic [31:0]  status_word;
  // Writes update the addressed register; reads answer in the next cycle.
  always_comb begin
    ctrl_nxt  = ctrl_r;
    peak_nxt  = peak_r;
    host_nxt  = host_r;
    cmd_nxt   = cmd_r;
    vset_nxt  = vset_r;
    curr_nxt  = curr_r;
    time_nxt  = time_r;
    rdata_nxt = RST_WORD;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: ctrl_nxt = reg_wdata[7:0];
        ADDR_PEAK: peak_nxt = reg_wdata[7:0];
        ADDR_HOST: host_nxt = reg_wdata[15:0];
        ADDR_CMD:  cmd_nxt  = reg_wdata;
        ADDR_VSET: vset_nxt = reg_wdata[15:0];
        ADDR_CURR: curr_nxt = reg_wdata[15:0];
        ADDR_TIME: time_nxt = reg_wdata[15:0];
        default:   ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:   rdata_nxt = {24'h000000, ctrl_r};
        ADDR_PEAK:   rdata_nxt = {24'h000000, peak_r};
        ADDR_HOST:   rdata_nxt = {16'h0000, host_r};
        ADDR_CMD:    rdata_nxt = cmd_r;
        ADDR_VSET:   rdata_nxt = {16'h0000, vset_r};
        ADDR_CURR:   rdata_nxt = {16'h0000, curr_r};
        ADDR_TIME:   rdata_nxt = {16'h0000, time_r};
        ADDR_STATUS: rdata_nxt = status_word;
        default:     rdata_nxt = RST_WORD;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= RST_BYTE;
      peak_r  <= RST_BYTE;
      host_r  <= RST_HALF;
      cmd_r   <= RST_WORD;
      vset_r  <= RST_HALF;
      curr_r  <= RST_HALF;
      time_r  <= RST_HALF;
      rdata_r <= RST_WORD;
    end else begin
      ctrl_r  <= ctrl_nxt;
      peak_r  <= peak_nxt;
      host_r  <= host_nxt;
      cmd_r   <= cmd_nxt;
      vset_r  <= vset_nxt;
      curr_r  <= curr_nxt;
      time_r  <= time_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata         = rdata_r;
  assign link_control_word = host_r[7:0];
  assign host_mode_word    = host_r[15:8];
  assign host_command_word = cmd_r;
  // ---------------------------------------------------------------
  // Supervision: detection, watchdog, faults, calibration
  // ---------------------------------------------------------------
  logic                   detected_r, detected_nxt, relock_r, relock_nxt;
  logic                   pwr_d_r, cal_d_r, clr_d_r, tog_d_r;
  logic [23:0]            wd_cnt_r, wd_cnt_nxt;
  logic                   wd_ok_r, wd_ok_nxt;
  logic [CRIT_FAULTS-1:0] crit_r, crit_nxt;
  logic                   cal_busy_r, cal_busy_nxt, cal_done_r, cal_done_nxt, cal_vld_r, cal_vld_nxt;
  logic [1:0]             cal_idx_r, cal_idx_nxt;
  logic [15:0]            cal_dat_r, cal_dat_nxt;
  logic                   link_ok, op_ok, cal_edge, clr_edge;
  assign link_ok  = ctrl_r.drive_unit_enable & ins_s & pwr_s & ~relock_r;
  assign cal_edge = ctrl_r.calibrate_request & ~cal_d_r;
  assign clr_edge = ctrl_r.fault_clear_request & ~clr_d_r;
  assign op_ok    = detected_r & cal_done_r & wd_ok_r & ~(|crit_r) & ~relock_r;
  always_comb begin
    detected_nxt = detected_r;
    relock_nxt   = relock_r;
    if (link_ok) begin
      detected_nxt = 1'b1;
    end
    if (!ctrl_r.drive_unit_enable || !ins_s) begin
      detected_nxt = 1'b0;
      relock_nxt   = 1'b0;
    end else if (detected_r && pwr_d_r && !pwr_s) begin
      relock_nxt   = 1'b1; // Power loss keeps the flag but needs an enable cycle.
    end
    wd_cnt_nxt = wd_cnt_r;
    wd_ok_nxt  = wd_ok_r;
    if (ctrl_r.safety_toggle_input != tog_d_r) begin
      wd_cnt_nxt = '0;
      wd_ok_nxt  = 1'b1;
    end else if (wd_cnt_r >= 24'(WD_TIMEOUT - 1)) begin
      wd_ok_nxt  = 1'b0;
    end else begin
      wd_cnt_nxt = wd_cnt_r + 24'h000001;
    end
    crit_nxt = (crit_r & ~{CRIT_FAULTS{clr_edge}}) | flt_s;
    cal_busy_nxt = cal_busy_r;
    cal_done_nxt = cal_done_r;
    cal_idx_nxt  = cal_idx_r;
    cal_vld_nxt  = 1'b0;
    cal_dat_nxt  = cal_dat_r;
    if (cal_busy_r) begin
      cal_vld_nxt = 1'b1;
      unique case (cal_idx_r)
        2'h0:    cal_dat_nxt = vset_r;
        2'h1:    cal_dat_nxt = curr_r;
        default: cal_dat_nxt = time_r;
      endcase
      cal_idx_nxt = cal_idx_r + 2'h1;
      if (cal_idx_r == CAL_LAST_WORD) begin
        cal_busy_nxt = 1'b0;
        cal_done_nxt = 1'b1;
      end
    end else if (cal_edge && detected_r) begin
      cal_busy_nxt = 1'b1;
      cal_done_nxt = 1'b0;
      cal_idx_nxt  = 2'h0;
    end
    if (!detected_r || relock_r) begin
      cal_busy_nxt = 1'b0;
      cal_done_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      detected_r <= 1'b0;
      relock_r   <= 1'b0;
      pwr_d_r    <= 1'b0;
      cal_d_r    <= 1'b0;
      clr_d_r    <= 1'b0;
      tog_d_r    <= 1'b0;
      wd_cnt_r   <= '0;
      wd_ok_r    <= 1'b0;
      crit_r     <= '0;
      cal_busy_r <= 1'b0;
      cal_done_r <= 1'b0;
      cal_idx_r  <= 2'h0;
      cal_vld_r  <= 1'b0;
      cal_dat_r  <= RST_HALF;
    end else begin
      detected_r <= detected_nxt;
      relock_r   <= relock_nxt;
      pwr_d_r    <= pwr_s;
      cal_d_r    <= ctrl_r.calibrate_request;
      clr_d_r    <= ctrl_r.fault_clear_request;
      tog_d_r    <= ctrl_r.safety_toggle_input;
      wd_cnt_r   <= wd_cnt_nxt;
      wd_ok_r    <= wd_ok_nxt;
      crit_r     <= crit_nxt;
      cal_busy_r <= cal_busy_nxt;
      cal_done_r <= cal_done_nxt;
      cal_idx_r  <= cal_idx_nxt;
      cal_vld_r  <= cal_vld_nxt;
      cal_dat_r  <= cal_dat_nxt;
    end
  end
  assign unit_link_active = link_ok;
  assign cal_word_valid   = cal_vld_r;
  assign cal_word_data    = cal_dat_r;
  // ---------------------------------------------------------------
  // Pulse phase controller
  // ---------------------------------------------------------------
  // Steps an interval: low byte counts steps, high bits count cycles per step.
  function automatic logic [17:0] tick_down(input logic [17:0] st, input logic [9:0] reload);
    logic [17:0] res;
    res = st;
    if (st[7:0] != 8'h00) begin
      if (st[17:8] == 10'h000) begin
        res = {reload, st[7:0] - 8'h01};
      end else begin
        res = {st[17:8] - 10'h001, st[7:0]};
      end
    end
    return res;
  endfunction : tick_down
  ids_phase_type phase_r, phase_nxt;
  logic [17:0]   peak_t_r, peak_t_nxt;
  logic [17:0]   hv_t_r, hv_t_nxt;
  logic [17:0]   ret_t_r, ret_t_nxt;
  ids_stage_type stage_r, stage_nxt;
  logic          pulse_on;
  assign pulse_on = fuel_s & op_ok & ctrl_r.injection_permit;
  // Fuel commands only start phases; the permit alone never starts one.
  always_comb begin
    phase_nxt  = phase_r;
    peak_t_nxt = tick_down(peak_t_r, PEAK_STEP_CYC);
    hv_t_nxt   = tick_down(hv_t_r, HV_STEP_CYC);
    ret_t_nxt  = tick_down(ret_t_r, RET_STEP_CYC);
    unique case (phase_r)
      PH_IDLE: begin
        if (pulse_on) begin
          phase_nxt  = PH_PULSE;
          peak_t_nxt = {PEAK_STEP_CYC, peak_r};
          hv_t_nxt   = {HV_STEP_CYC, time_r[7:0]};
        end
      end
      PH_PULSE: begin
        if (!pulse_on) begin
          phase_nxt = PH_RETURN;
          ret_t_nxt = {RET_STEP_CYC, time_r[15:8]};
        end
      end
      PH_RETURN: begin
        if (ret_t_r[7:0] == 8'h00) begin
          phase_nxt = PH_IDLE;
        end
      end
      default: phase_nxt = PH_IDLE;
    endcase
    stage_nxt.boost_run    = op_ok & ctrl_r.boost_supply_enable;
    stage_nxt.drive_enable = op_ok & ctrl_r.injection_permit;
    stage_nxt.voltage_setpoint = (phase_r == PH_IDLE) ? vset_r[7:0] : vset_r[15:8];
    stage_nxt.current_target = (phase_r == PH_PULSE && peak_t_r[7:0] != 8'h00) ? curr_r[7:0] : curr_r[15:8];
    stage_nxt.high_voltage_drive = (phase_r == PH_PULSE) && (hv_t_r[7:0] != 8'h00) && op_ok;
    stage_nxt.energy_return = (phase_r == PH_RETURN) && (ret_t_r[7:0] != 8'h00) && op_ok;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r  <= PH_IDLE;
      peak_t_r <= '0;
      hv_t_r   <= '0;
      ret_t_r  <= '0;
      stage_r  <= '0;
    end else begin
      phase_r  <= phase_nxt;
      peak_t_r <= peak_t_nxt;
      hv_t_r   <= hv_t_nxt;
      ret_t_r  <= ret_t_nxt;
      stage_r  <= stage_nxt;
    end
  end
  assign stage_cmd   = stage_r;
  assign status_word = {14'h0000, phase_r, 1'b0, crit_r, 3'h0, link_ok, wd_ok_r, |crit_r, cal_done_r, detected_r};
endmodule : ids_supervisor

// >>> testbench/ids_sup_sva.sv
/*
  Port checker for the injector driver supervisor.
  Assumes it is bound into ids_supervisor and shares its clock and reset.
*/
module ids_sup_sva
  import ids_pkg::*;
#(
  parameter int WD_TIMEOUT = 50
) (
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic [6:0]    critical_fault_in,
  input wire logic          unit_inserted,
  input wire logic          unit_powered,
  input wire logic          unit_link_active,
  input wire logic          cal_word_valid,
  input wire logic [15:0]   cal_word_data,
  input wire ids_stage_type stage_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  ctl_r, ctl_nxt;
  logic [15:0] vs_r, vs_nxt, cu_r, cu_nxt, tm_r, tm_nxt;
  logic [31:0] wd_r, wd_nxt;
  // Shadow of the written control and setting registers, plus toggle age.
  always_comb begin
    ctl_nxt = ctl_r;
    vs_nxt = vs_r;
    cu_nxt = cu_r;
    tm_nxt = tm_r;
    wd_nxt = wd_r + 32'h1;
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctl_nxt = reg_wdata[7:0];
      if (reg_wdata[5] != ctl_r[5]) wd_nxt = 32'h0;
    end
    if (reg_wr && reg_addr == ADDR_VSET) vs_nxt = reg_wdata[15:0];
    if (reg_wr && reg_addr == ADDR_CURR) cu_nxt = reg_wdata[15:0];
    if (reg_wr && reg_addr == ADDR_TIME) tm_nxt = reg_wdata[15:0];
  end
  // Registers the shadows.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 8'h00;
      vs_r <= 16'h0000;
      cu_r <= 16'h0000;
      tm_r <= 16'h0000;
      wd_r <= 32'h0;
    end else begin
      ctl_r <= ctl_nxt;
      vs_r <= vs_nxt;
      cu_r <= cu_nxt;
      tm_r <= tm_nxt;
      wd_r <= wd_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_link;
    unit_link_active |-> $past(unit_inserted, 2) && $past(unit_powered, 2);
  endproperty
  a_link: assert property (p_link) else $error("link without unit");
  property p_en_off;
    !ctl_r[0] |-> !unit_link_active;
  endproperty
  a_en_off: assert property (p_en_off) else $error("link while disabled");
  property p_permit;
    !$past(ctl_r[1]) |-> !stage_cmd.drive_enable;
  endproperty
  a_permit: assert property (p_permit) else $error("drive without permit");
  property p_boost;
    !$past(ctl_r[2]) |-> !stage_cmd.boost_run;
  endproperty
  a_boost: assert property (p_boost) else $error("boost while disabled");
  property p_fault;
    (|critical_fault_in) [*3] |-> ##[1:3] (!stage_cmd.drive_enable && !stage_cmd.boost_run);
  endproperty
  a_fault: assert property (p_fault) else $error("running under fault");
  property p_cal_len;
    $rose(cal_word_valid) |-> cal_word_valid [*3] ##1 !cal_word_valid;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal burst length");
  property p_cal_data;
    $rose(cal_word_valid) |-> cal_word_data == vs_r ##1 cal_word_data == cu_r ##1 cal_word_data == tm_r;
  endproperty
  a_cal_data: assert property (p_cal_data) else $error("cal word content");
  property p_wd;
    wd_r > WD_TIMEOUT + 8 |-> !stage_cmd.drive_enable && !stage_cmd.boost_run;
  endproperty
  a_wd: assert property (p_wd) else $error("running without toggles");
  c_cal: cover property ($rose(cal_word_valid));
  c_hv: cover property (stage_cmd.high_voltage_drive);
  c_ret: cover property (stage_cmd.energy_return);
endmodule : ids_sup_sva

bind ids_supervisor ids_sup_sva #(.WD_TIMEOUT(WD_TIMEOUT)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .critical_fault_in(critical_fault_in), .unit_inserted(unit_inserted), .unit_powered(unit_powered),
  .unit_link_active(unit_link_active), .cal_word_valid(cal_word_valid), .cal_word_data(cal_word_data),
  .stage_cmd(stage_cmd));

// >>> testbench/ids_stage_model.sv
/*
  Power stage stand-in: unit pins, fuel command, fault pins, word counter.
  Assumes one bench process calls its tasks at a time.
*/
module ids_stage_model (
  input  wire logic       mclk,
  output logic            unit_inserted,
  output logic            unit_powered,
  output logic            fuel_command,
  output logic      [6:0] critical_fault_in,
  input  wire logic       cal_word_valid,
  input  wire logic [15:0] cal_word_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_words = 0;
  logic [15:0] last_word = 16'h0000;
  // Pins start out with no unit present.
  initial begin
    unit_inserted = 1'b0;
    unit_powered = 1'b0;
    fuel_command = 1'b0;
    critical_fault_in = 7'h00;
  end
  // Counts calibration words taken by the stage.
  always @(posedge mclk) begin
    if (cal_word_valid) begin
      n_words   <= n_words + 1;
      last_word <= cal_word_data;
    end
  end
  task automatic plug(input logic i, input logic p);
    @(posedge mclk);
    unit_inserted <= i;
    unit_powered <= p;
  endtask : plug
  task automatic fire(input int n);
    @(posedge mclk);
    fuel_command <= 1'b1;
    repeat (n) @(posedge mclk);
    fuel_command <= 1'b0;
  endtask : fire
  task automatic fault(input logic [6:0] v);
    @(posedge mclk);
    critical_fault_in <= v;
  endtask : fault
endmodule : ids_stage_model

// >>> testbench/test_injector_driver_supervisor.sv
/*
  Self-checking bench of the injector driver supervisor.
  Assumes the stage model beside the design and the bound checker.
*/
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module test_injector_driver_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import ids_pkg::*;
  localparam int WDT = 3000;
  logic          mclk = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    addr = 8'h00;
  logic [31:0]   wd = 32'h0, rdat, rv, hcw;
  logic          wr = 1'b0, rdst = 1'b0, ins, pwr, fuel, lnk, cv;
  logic [6:0]    flt;
  logic [15:0]   cd;
  logic [7:0]    ctl = 8'h00, lcw, hmw;
  ids_stage_type st;
  int            error_cnt = 0, n_tests = 0;
  ids_supervisor #(.WD_TIMEOUT(WDT)) dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rdst), .reg_rdata(rdat), .unit_inserted(ins), .unit_powered(pwr),
    .fuel_command(fuel), .critical_fault_in(flt), .unit_link_active(lnk), .cal_word_valid(cv),
    .cal_word_data(cd), .link_control_word(lcw), .host_mode_word(hmw), .host_command_word(hcw),
    .stage_cmd(st));
  ids_stage_model pm (.mclk(mclk), .unit_inserted(ins), .unit_powered(pwr), .fuel_command(fuel),
    .critical_fault_in(flt), .cal_word_valid(cv), .cal_word_data(cd));
  // Free-running fabric clock.
  initial forever #5 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rdst <= 1'b1;
    @(posedge mclk);
    rdst <= 1'b0;
    #1 rv = rdat;
  endtask : rd
  task automatic setc(input logic [7:0] v);
    ctl = {2'b00, ~ctl[5], v[4:0]};
    wrr(ADDR_CTRL, {24'h0, ctl});
  endtask : setc
  task automatic t_detect();
    pm.plug(1'b1, 1'b1);
    cyc(6);
    rd(ADDR_STATUS);
    `CHK("detect_off", 1'b0, rv[0])
    setc(8'h01);
    cyc(4);
    rd(ADDR_STATUS);
    `CHK("detect", 1'b1, rv[0])
    `CHK("done0", 1'b0, rv[1])
    `CHK("link", 1'b1, lnk)
    rd(8'h20);
    `CHK("unmapped", 32'h0, rv)
    wrr(ADDR_HOST, 32'h0000_A55A);
    wrr(ADDR_CMD, 32'h1234_5678);
    cyc(2);
    `CHK("ctlw", 8'h5A, lcw)
    `CHK("mode", 8'hA5, hmw)
    `CHK("cmd", 32'h1234_5678, hcw)
  endtask : t_detect
  task automatic t_cal();
    wrr(ADDR_VSET, 32'h5A10);
    wrr(ADDR_CURR, 32'h3C20);
    wrr(ADDR_TIME, 32'h0101);
    wrr(ADDR_PEAK, 32'h01);
    setc(8'h09);
    cyc(8);
    `CHK("words", 3, pm.n_words)
    `CHK("last_word", 16'h0101, pm.last_word)
    rd(ADDR_STATUS);
    `CHK("done", 1'b1, rv[1])
    setc(8'h09);
    cyc(8);
    `CHK("level", 3, pm.n_words)
    setc(8'h01);
    setc(8'h09);
    cyc(8);
    `CHK("again", 6, pm.n_words)
  endtask : t_cal
  task automatic t_pulse();
    int np, nh, nr, nd;
    bit hs;
    np = 0;
    nh = 0;
    nr = 0;
    nd = 0;
    hs = 0;
    setc(8'h07);
    cyc(4);
    `CHK("boost", 1'b1, st.boost_run)
    `CHK("drive", 1'b1, st.drive_enable)
    `CHK("no_hv", 1'b0, st.high_voltage_drive)
    `CHK("idle_v", 8'h10, st.voltage_setpoint)
    fork
      pm.fire(400);
      for (int i = 0; i < 1100; i++) begin
        @(posedge mclk);
        #1;
        if (np > 0 && st.current_target == 8'h3C) hs = 1;
        if (fuel && !hs && st.current_target == 8'h20) np++;
        if (fuel && hs && st.current_target == 8'h3C) nd++;
        if (st.high_voltage_drive) nh++;
        if (st.energy_return) nr++;
        if (i == 300) `CHK("act_v", 8'h5A, st.voltage_setpoint)
      end
    join
    `CHK("peak", 1'b1, np inside {[192:200]})
    `CHK("hold", 1'b1, nd inside {[196:204]})
    `CHK("hv", 1'b1, nh inside {[152:160]})
    `CHK("ret", 1'b1, nr inside {[623:631]})
    `CHK("idle_v2", 8'h10, st.voltage_setpoint)
  endtask : t_pulse
  task automatic t_fault();
    pm.fault(7'h09);
    cyc(6);
    pm.fault(7'h00);
    cyc(4);
    rd(ADDR_STATUS);
    `CHK("flt", 8'h13, {rv[14:8], rv[2]})
    `CHK("flt_drv", 1'b0, st.drive_enable)
    setc(8'h17);
    cyc(4);
    rd(ADDR_STATUS);
    `CHK("clr", 8'h00, {rv[14:8], rv[2]})
    setc(8'h07);
    cyc(4);
    `CHK("resume", 1'b1, st.drive_enable)
  endtask : t_fault
  task automatic t_wd();
    cyc(WDT + 20);
    `CHK("wd_drv", 1'b0, st.drive_enable)
    `CHK("wd_bst", 1'b0, st.boost_run)
    setc(8'h07);
    cyc(4);
    `CHK("wd_back", 1'b1, st.drive_enable)
  endtask : t_wd
  task automatic t_unplug();
    pm.plug(1'b1, 1'b0);
    cyc(6);
    rd(ADDR_STATUS);
    `CHK("relock", 2'b01, {rv[4], rv[0]})
    `CHK("relock_drv", 1'b0, st.drive_enable)
    setc(8'h00);
    cyc(4);
    rd(ADDR_STATUS);
    `CHK("dropped", 1'b0, rv[0])
  endtask : t_unplug
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Reset, then the scenarios in order.
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    t_detect();
    t_cal();
    t_pulse();
    t_fault();
    t_wd();
    t_unplug();
    report_and_stop();
  end
endmodule : test_injector_driver_supervisor
